// ### eapg_pkg.sv
// eapg_pkg: constants and types of the event alert pulse generator.
// assumes a single 50 MHz clock and an AHB-Lite register slave.

package eapg_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 50; // mclk rate
  localparam int T_PULSE_US = 100; // alert low time
  localparam int T_GAP_US = 100; // least high time between pulses
  localparam int T_CFG_FILT_US = 7; // config select filter
  localparam int PULSE_CYC_DEF = T_PULSE_US * CLK_MHZ;
  localparam int GAP_CYC_DEF = T_GAP_US * CLK_MHZ;
  localparam int CFG_FILT_CYC = T_CFG_FILT_US * CLK_MHZ;
  localparam int CNT_W = 16; // pulse / gap counter width
  localparam int FILT_W = 9; // filter counter width

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_WAKE_EN_1 = 8'h04;
  localparam logic [7:0] OFF_WAKE_EN_2 = 8'h08;
  localparam logic [7:0] OFF_WAKE_FLAGS_1 = 8'h0c;
  localparam logic [7:0] OFF_WAKE_FLAGS_2 = 8'h10;
  localparam logic [7:0] OFF_FAIL_FLAGS = 8'h14;
  localparam logic [7:0] OFF_WAKE_LEVEL = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFF_ALERT_STATE = 8'h24;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_GLOBAL_BIT = 0; // class select
  localparam int IRQ_PULSE_BIT = 0; // an alert pulse started
  localparam int IRQ_STOP_BIT = 1; // stop entry with flags left
  // fail bits 0..5: undervolt, watchdog, short, overtemp 2,
  // fail output, power-on; these never raise an alert
  localparam logic [15:0] FAIL_NOALERT_MASK = 16'h003f;
  localparam logic RST_GLOBAL = 1'h0; // wake class by default
  localparam logic [7:0] RST_WAKE_EN = 8'h00;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_INIT, MODE_NORMAL, MODE_STOP, MODE_OTHER
  } eapg_mode_t;

  typedef enum logic [1:0] {AL_IDLE, AL_PULSE, AL_GAP} eapg_alert_t;

  // incoming one-cycle event pulses
  typedef struct packed {
    logic [7:0] wake1;
    logic [7:0] wake2;
    logic [15:0] fail;
  } eapg_events_t;

  // whole state of the generator
  typedef struct packed {
    logic wr_pend;
    logic [7:0] addr;
    logic [31:0] hrdata;
    logic global_cls;
    logic [7:0] en1;
    logic [7:0] en2;
    logic [7:0] flags1;
    logic [7:0] flags2;
    logic [15:0] fail_flags;
    logic [7:0] cap1;
    logic [7:0] cap2;
    logic [15:0] cap_fail;
    logic stop_pend;
    eapg_mode_t prev_mode;
    eapg_alert_t st;
    logic [CNT_W-1:0] cnt;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [FILT_W-1:0] fcnt;
    logic cfg_sel;
  } eapg_state_t;

endpackage

// ### eapg_top.sv
// eapg_top: alert pulse generator with its AHB-Lite register slave.
// assumes all inputs synchronous to mclk; mode comes from the mode
// state machine elsewhere and is only read here.
//
// Operation
// R1: alert drives pin low one pulse width
// R2: pin stays high at least the gap
// R3: alerts never change the operating mode
// R4: class bit picks wake-only or global alerts
// R5: wake flags alert only when source enabled
// R6: global class adds failures, never level view
// R7: restart and fail-safe causes never alert
// R8: stop entry with uncleared wake flags alerts
// R9: status registers update at pulse falling edge
// R10: events stay latched until software clears
// R11: host should reread status after clearing
// R12: init mode pin is filtered config input
// R13: events during pulse or gap wait pending
// R14: other modes keep pin high, no pulses

`timescale 1ns/1ps
`default_nettype none

module eapg_top
  import eapg_pkg::*;
#(
  parameter int PULSE_CYC = PULSE_CYC_DEF,
  parameter int GAP_CYC = GAP_CYC_DEF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // device side
  input wire eapg_mode_t mode,
  input wire eapg_events_t evt,
  input wire logic [7:0] wake_level_1,
  input wire logic [7:0] wake_level_2,
  output logic hw_config_sel,
  // alert pin, push/pull, input in init mode
  input wire logic alert_pin_i,
  output logic alert_pin_o,
  output logic alert_pin_oe,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // state and next state
  // ----------------------------------------------------------------
  eapg_state_t s; // registered state
  eapg_state_t next_s; // next state
  logic active; // normal or stop mode
  logic trigger; // some pending event asks for a pulse
  logic start; // pulse begins this cycle
  logic xfer; // pending events move into visible flags
  logic stop_entry; // stop entered with wake flags left
  logic wr_acc; // write address phase taken
  logic rd_acc; // read address phase taken
  logic [7:0] clr1; // software clear of wake flags 1
  logic [7:0] clr2; // software clear of wake flags 2
  logic [15:0] clr_fail; // software clear of fail flags
  logic [1:0] clr_irq; // software clear of irq status
  logic [1:0] set_irq; // irq events this cycle

  assign active = (mode == MODE_NORMAL) || (mode == MODE_STOP);
  assign wr_acc = hsel && hready && htrans[1] && hwrite;
  assign rd_acc = hsel && hready && htrans[1] && !hwrite;

  // wake sources count only when enabled; failures only in global
  // class and only those that do not force restart or fail-safe;
  // the live level inputs never enter here
  assign trigger = (|(s.cap1 & s.en1)) // R5
    || (|(s.cap2 & s.en2)) // R5
    || (s.global_cls && (|(s.cap_fail & ~FAIL_NOALERT_MASK))) // R6 R7
    || s.stop_pend; // R8

  // no pulse outside normal and stop; pending ones wait for the gap
  assign start = (s.st == AL_IDLE) && active && trigger; // R13 R14

  // captured events reach software at the falling pin edge; events
  // that raise no alert are shown at once while the generator idles
  assign xfer = start || ((s.st == AL_IDLE) && !trigger); // R9

  // entering stop while software has not cleared every wake flag
  assign stop_entry = (mode == MODE_STOP) && (s.prev_mode != MODE_STOP)
    && ((|s.flags1) || (|s.flags2)); // R8

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  function automatic logic [31:0] rd_mux(input eapg_state_t v,
                                         input logic [7:0] a,
                                         input logic [15:0] lvl);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      OFF_CTRL: d[CTRL_GLOBAL_BIT] = v.global_cls;
      OFF_WAKE_EN_1: d[7:0] = v.en1;
      OFF_WAKE_EN_2: d[7:0] = v.en2;
      OFF_WAKE_FLAGS_1: d[7:0] = v.flags1;
      OFF_WAKE_FLAGS_2: d[7:0] = v.flags2;
      OFF_FAIL_FLAGS: d[15:0] = v.fail_flags;
      OFF_WAKE_LEVEL: d[15:0] = lvl; // live, never latched R10
      OFF_IRQ_STAT: d[1:0] = v.irq_stat;
      OFF_IRQ_MASK: d[1:0] = v.irq_mask;
      OFF_ALERT_STATE: d[4:0] = {v.stop_pend, v.cfg_sel, 1'b0, v.st};
      default: d = 32'h0000_0000; // unmapped reads as zero
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    clr1 = 8'h00;
    clr2 = 8'h00;
    clr_fail = 16'h0000;
    clr_irq = 2'h0;
    set_irq = 2'h0;

    // bus write lands in its data phase
    if (s.wr_pend) begin
      unique case (s.addr)
        OFF_CTRL: next_s.global_cls = hwdata[CTRL_GLOBAL_BIT]; // R4
        OFF_WAKE_EN_1: next_s.en1 = hwdata[7:0];
        OFF_WAKE_EN_2: next_s.en2 = hwdata[7:0];
        OFF_WAKE_FLAGS_1: clr1 = hwdata[7:0];
        OFF_WAKE_FLAGS_2: clr2 = hwdata[7:0];
        OFF_FAIL_FLAGS: clr_fail = hwdata[15:0];
        OFF_IRQ_STAT: clr_irq = hwdata[1:0];
        OFF_IRQ_MASK: next_s.irq_mask = hwdata[1:0];
        default: ; // read-only or unmapped: ignored
      endcase
    end
    next_s.wr_pend = wr_acc;
    if (wr_acc) begin
      next_s.addr = haddr[7:0];
    end

    // capture registers: a new event beats the transfer clear
    next_s.cap1 = (xfer ? 8'h00 : s.cap1) | evt.wake1; // R13
    next_s.cap2 = (xfer ? 8'h00 : s.cap2) | evt.wake2; // R13
    next_s.cap_fail = (xfer ? 16'h0000 : s.cap_fail) | evt.fail;

    // sticky visible flags: hardware set wins over software clear
    next_s.flags1 = (s.flags1 & ~clr1) | (xfer ? s.cap1 : 8'h00); // R10
    next_s.flags2 = (s.flags2 & ~clr2) | (xfer ? s.cap2 : 8'h00); // R10
    next_s.fail_flags = (s.fail_flags & ~clr_fail)
      | (xfer ? s.cap_fail : 16'h0000); // R10

    // stop entry request stays until its pulse is issued
    next_s.stop_pend = (s.stop_pend && !start) || stop_entry; // R8
    next_s.prev_mode = mode;

    // pulse sequencer; it only reads mode, never drives it
    unique case (s.st) // R3
      AL_IDLE: begin
        if (start) begin
          next_s.st = AL_PULSE;
          next_s.cnt = '0;
        end
      end
      AL_PULSE: begin
        // leaving the active modes cuts the pulse but keeps the gap
        if (!active || (s.cnt == CNT_W'(PULSE_CYC - 1))) begin // R1 R14
          next_s.st = AL_GAP;
          next_s.cnt = '0;
        end else begin
          next_s.cnt = s.cnt + 1'b1;
        end
      end
      AL_GAP: begin
        if (s.cnt == CNT_W'(GAP_CYC - 1)) begin // R2
          next_s.st = AL_IDLE;
          next_s.cnt = '0;
        end else begin
          next_s.cnt = s.cnt + 1'b1;
        end
      end
    endcase

    // interrupt status, set wins over write-one-to-clear
    set_irq[IRQ_PULSE_BIT] = start;
    set_irq[IRQ_STOP_BIT] = stop_entry;
    next_s.irq_stat = (s.irq_stat & ~clr_irq) | set_irq;

    // config select filter: a level must hold for the filter time
    if (mode == MODE_INIT) begin
      if (alert_pin_i != s.cfg_sel) begin
        if (s.fcnt == FILT_W'(CFG_FILT_CYC - 1)) begin // R12
          next_s.cfg_sel = alert_pin_i;
          next_s.fcnt = '0;
        end else begin
          next_s.fcnt = s.fcnt + 1'b1;
        end
      end else begin
        next_s.fcnt = '0; // glitch shorter than filter: dropped
      end
    end else begin
      next_s.fcnt = '0;
    end

    // read data from the post-write view, so a read right after a
    // write to the same register is never stale
    if (rd_acc) begin
      next_s.hrdata = rd_mux(next_s, haddr[7:0],
                             {wake_level_2, wake_level_1});
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.global_cls <= RST_GLOBAL; // R4
      s.en1 <= RST_WAKE_EN;
      s.en2 <= RST_WAKE_EN;
      s.irq_mask <= RST_IRQ_MASK;
      s.st <= AL_IDLE;
      s.prev_mode <= MODE_INIT;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0; // always OKAY
  assign hrdata = s.hrdata;
  assign hw_config_sel = s.cfg_sel;
  // pin is an input in init, high in any other idle state
  assign alert_pin_oe = (mode != MODE_INIT); // R12 R14
  assign alert_pin_o = !((s.st == AL_PULSE) && active); // R1 R14
  assign irq = |(s.irq_stat & s.irq_mask);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] lo_cnt; // consecutive low cycles of the pin
  logic [CNT_W-1:0] hi_cnt; // high cycles since last pulse, saturates

  always_ff @(posedge mclk) begin
    if (rst) begin
      lo_cnt <= '0;
      hi_cnt <= '1;
    end else begin
      lo_cnt <= alert_pin_o ? '0 : lo_cnt + 1'b1;
      if (!alert_pin_o) begin
        hi_cnt <= '0;
      end else if (hi_cnt != '1) begin
        hi_cnt <= hi_cnt + 1'b1;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence pulse_last_low;
    (s.st == AL_PULSE) && active && (s.cnt == CNT_W'(PULSE_CYC - 1));
  endsequence

  sequence pulse_released;
    alert_pin_o && (s.st == AL_GAP);
  endsequence

  pulse_width_a: assert property ( // R1
    pulse_last_low |-> (lo_cnt == CNT_W'(PULSE_CYC - 1)) ##1 pulse_released)
    else $error("alert pulse width wrong");

  pulse_gap_a: assert property ( // R2
    start |-> (hi_cnt >= CNT_W'(GAP_CYC)))
    else $error("alert gap shorter than minimum");

  idle_high_a: assert property ( // R14
    (!active && (mode != MODE_INIT)) |-> (alert_pin_oe && alert_pin_o))
    else $error("pin not high outside active modes");

  init_input_a: assert property ( // R12
    (mode == MODE_INIT) |-> (!alert_pin_oe && (s.st != AL_PULSE
      || !alert_pin_o == 1'b0)))
    else $error("pin driven in init mode");

  flag_update_a: assert property ( // R9
    start |=> ((($past(s.cap1) & ~s.flags1) == 8'h00)
      && !alert_pin_o))
    else $error("flags not updated at falling edge");

  no_cause_a: assert property ( // R7
    ((s.st == AL_IDLE) && !trigger && !stop_entry) |=> alert_pin_o)
    else $error("pulse without an alerting cause");

  stop_entry_a: assert property ( // R8
    stop_entry |=> s.stop_pend ##0 (s.st != AL_IDLE || start))
    else $error("stop entry alert not raised");

  flag_hold_a: assert property ( // R10
    (s.flags1[0] && !(s.wr_pend && (s.addr == OFF_WAKE_FLAGS_1)))
      |=> s.flags1[0])
    else $error("wake flag lost without clear");

  // guards on pending events, pulse cut, class, stop entry and the config filter;
  // each catches a sequencer or flag slip the pin count would hide
  hold_pending_a: assert property ( // R13
    ((evt.wake1 != 8'h00) && (s.st != AL_IDLE))
      |=> ((s.cap1 & $past(evt.wake1)) == $past(evt.wake1)))
    else $error("event during pulse or gap lost");

  cut_pulse_a: assert property ( // R14
    ((s.st == AL_PULSE) && !active)
      |=> ((s.st == AL_GAP) && (s.cnt == '0)))
    else $error("pulse not cut outside active modes");

  wake_class_a: assert property ( // R4
    (!s.global_cls && !s.stop_pend && !(|(s.cap1 & s.en1))
      && !(|(s.cap2 & s.en2))) |-> !start)
    else $error("failure alert raised in wake class");

  stop_irq_a: assert property ( // R8
    stop_entry |=> s.irq_stat[IRQ_STOP_BIT])
    else $error("stop entry interrupt not set");

  cfg_filter_a: assert property ( // R12
    !((mode == MODE_INIT) && (s.fcnt == FILT_W'(CFG_FILT_CYC - 1)))
      |=> $stable(s.cfg_sel))
    else $error("config select taken before filter time");

endmodule

`default_nettype wire

// ### eapg_host_model.sv
// eapg_host_model: host side of the alert pin, measures pulses.
// assumes one clock; drives the pin only while the device releases it.
`timescale 1ns/1ps
`default_nettype none
module eapg_host_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pin as the device drives it
  input wire logic alert_pin_o,
  input wire logic alert_pin_oe,
  // level the host puts on the pin in init mode
  input wire logic cfg_drive,
  // resolved pin level and measurements
  output logic alert_pin_i,
  output logic [7:0] pulses,
  output logic [15:0] low_len,
  output logic [15:0] gap_len
);
  logic prev; // pin level one cycle ago
  logic [15:0] run; // cycles since last change
  // wire level: device wins while enabled, host otherwise
  assign alert_pin_i = alert_pin_oe ? alert_pin_o : cfg_drive;
  // ----------------------------------------------------------------
  // pulse and gap measurement, only while the pin is an output
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      prev <= 1'b1;
      run <= 16'h0000;
      pulses <= 8'h00;
      low_len <= 16'h0000;
      gap_len <= 16'h0000;
    end else if (alert_pin_oe) begin
      prev <= alert_pin_i;
      if (alert_pin_i !== prev) begin
        run <= 16'h0001;
        if (prev === 1'b0) begin
          low_len <= run;
        end else begin
          gap_len <= run;
          pulses <= pulses + 8'h01;
        end
      end else begin
        run <= run + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb_top.sv
// tb_top: self-checking bench of the alert pulse generator.
// assumes short pulse and gap parameters and a zero-wait ahb slave.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import eapg_pkg::*;
  localparam int PC = 8; // shortened pulse width
  localparam int GC = 6; // shortened gap
  logic mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, hw_config_sel, pin_i, pin_o, pin_oe, irq;
  logic cfg_drive = 1'b0;
  eapg_mode_t mode = MODE_NORMAL;
  eapg_events_t evt = '0;
  logic [7:0] lvl1 = 8'h00, lvl2 = 8'h00, pulses, np;
  logic [15:0] low_len, gap_len;
  int mismatches = 0, tests_run = 0, cyc = 0;
  always #10 mclk = ~mclk;
  eapg_top #(.PULSE_CYC(PC), .GAP_CYC(GC)) dut_u (.mclk(mclk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mode(mode),
    .evt(evt), .wake_level_1(lvl1), .wake_level_2(lvl2),
    .hw_config_sel(hw_config_sel), .alert_pin_i(pin_i),
    .alert_pin_o(pin_o), .alert_pin_oe(pin_oe), .irq(irq));
  eapg_host_model host_u (.mclk(mclk), .rst(rst), .alert_pin_o(pin_o),
    .alert_pin_oe(pin_oe), .cfg_drive(cfg_drive), .alert_pin_i(pin_i),
    .pulses(pulses), .low_len(low_len), .gap_len(gap_len));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one ahb single transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  // one-cycle event pulse
  task automatic fire(input logic [31:0] v);
    @(posedge mclk);
    evt <= v;
    @(posedge mclk);
    evt <= '0;
  endtask
  // wait for pulse number n to finish, or idle for a while
  task automatic wait_done(input logic [7:0] n);
    for (int i = 0; i < 60 && !(pulses === n && pin_o === 1'b1); i++)
      @(posedge mclk);
    repeat (3) @(posedge mclk);
    chk("pulse count", {24'h0, pulses}, {24'h0, n});
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk("ctrl", OFF_CTRL, 32'h0);
    rchk("wake enable", OFF_WAKE_EN_1, 32'h0);
    rchk("unmapped", 8'h3c, 32'h0);
    rchk("alert state", OFF_ALERT_STATE, 32'h0);
    chk("idle pin", {31'h0, pin_o}, 32'h1);
    chk("hresp okay", {31'h0, hresp}, 32'h0);
  endtask
  task automatic t_wake();
    xfer(1'b1, OFF_WAKE_EN_1, 32'h1);
    fire({8'h03, 8'h00, 16'h0});
    np = np + 8'h01;
    wait_done(np);
    chk("pulse width", {16'h0, low_len}, PC);
    rchk("flags latched", OFF_WAKE_FLAGS_1, 32'h3);
    rchk("irq stat", OFF_IRQ_STAT, 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    xfer(1'b1, OFF_IRQ_MASK, 32'h1);
    // the write lands on the edge the task returns at; look once settled
    @(negedge mclk);
    chk("irq raised", {31'h0, irq}, 32'h1);
    xfer(1'b1, OFF_IRQ_STAT, 32'h1);
    @(negedge mclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    xfer(1'b1, OFF_WAKE_FLAGS_1, 32'h1);
    rchk("reread", OFF_WAKE_FLAGS_1, 32'h2);
    fire({8'h02, 8'h00, 16'h0}); // disabled source only
    wait_done(np);
    xfer(1'b1, OFF_WAKE_FLAGS_1, 32'h2);
    // second wake register takes the same path
    xfer(1'b1, OFF_WAKE_EN_2, 32'h1);
    fire({8'h00, 8'h01, 16'h0});
    np = np + 8'h01;
    wait_done(np);
    rchk("flags 2", OFF_WAKE_FLAGS_2, 32'h1);
    xfer(1'b1, OFF_WAKE_FLAGS_2, 32'h1);
    rchk("flags 2 reread", OFF_WAKE_FLAGS_2, 32'h0);
  endtask
  task automatic t_merge();
    fire({8'h01, 8'h00, 16'h0});
    fire({8'h01, 8'h00, 16'h0}); // lands inside the pulse
    repeat (PC) @(posedge mclk);
    fire({8'h01, 8'h00, 16'h0}); // lands inside the gap
    np = np + 8'h02;
    wait_done(np);
    chk("gap kept", {31'h0, gap_len >= 16'(GC)}, 32'h1);
    chk("gap tight", {31'h0, gap_len <= 16'(GC + 2)}, 32'h1);
    xfer(1'b1, OFF_WAKE_FLAGS_1, 32'hff);
  endtask
  task automatic t_class();
    fire({8'h00, 8'h00, 16'h0040}); // alerting fail, wake class
    wait_done(np);
    xfer(1'b1, OFF_CTRL, 32'h1);
    fire({8'h00, 8'h00, 16'h0040});
    np = np + 8'h01;
    wait_done(np);
    for (int b = 0; b < 6; b++) begin
      fire({16'h0, 16'h0001 << b});
      wait_done(np);
    end
    lvl1 <= 8'h5a;
    lvl2 <= 8'ha5;
    wait_done(np);
    rchk("level view", OFF_WAKE_LEVEL, 32'ha55a);
    rchk("fail flags", OFF_FAIL_FLAGS, 32'h7f);
    xfer(1'b1, OFF_FAIL_FLAGS, 32'hffff);
    xfer(1'b1, OFF_CTRL, 32'h0);
  endtask
  task automatic t_stop();
    fire({8'h02, 8'h00, 16'h0}); // flag without alert
    wait_done(np);
    @(posedge mclk);
    mode <= MODE_STOP;
    np = np + 8'h01;
    wait_done(np);
    // the stop pulse sets the pulse bit as well
    rchk("stop irq", OFF_IRQ_STAT, 32'h3);
    chk("mode kept", {30'h0, mode}, {30'h0, MODE_STOP});
    mode <= MODE_NORMAL;
    xfer(1'b1, OFF_WAKE_FLAGS_1, 32'hff);
    xfer(1'b1, OFF_IRQ_STAT, 32'h3);
  endtask
  task automatic t_other();
    fire({8'h01, 8'h00, 16'h0});
    repeat (3) @(posedge mclk);
    mode <= MODE_OTHER; // leaves normal while the pin is low
    np = np + 8'h01;
    repeat (2) @(posedge mclk);
    chk("pulse cut", {31'h0, pin_o}, 32'h1);
    fire({8'h01, 8'h00, 16'h0});
    wait_done(np);
    chk("pin high", {31'h0, pin_o}, 32'h1);
    mode <= MODE_NORMAL;
    np = np + 8'h01;
    wait_done(np);
    xfer(1'b1, OFF_WAKE_FLAGS_1, 32'hff);
  endtask
  task automatic t_init();
    @(posedge mclk);
    mode <= MODE_INIT;
    cfg_drive <= 1'b1;
    repeat (300) @(posedge mclk);
    chk("pin released", {31'h0, pin_oe}, 32'h0);
    chk("cfg filtered", {31'h0, hw_config_sel}, 32'h0);
    repeat (60) @(posedge mclk);
    chk("cfg taken", {31'h0, hw_config_sel}, 32'h1);
    rchk("cfg in state", OFF_ALERT_STATE, 32'h8);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    np = 8'h00;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_wake();
    t_merge();
    t_class();
    t_stop();
    t_other();
    t_init();
    give_verdict();
  end
endmodule
`default_nettype wire
